// >>> rtl/viu_pkg.sv
package viu_pkg;
    localparam int NUM_SRC = 32;
    localparam int SRC_ID_W = 5;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [19:0] VIU_BASE_PAGE = 20'hfffff;
    // external sources; choice of this build, bit n is source n
    localparam logic [31:0] EXT_SRC_MASK = 32'he000_0001;
    // byte offsets inside the window
    localparam logic [11:0] OFF_ACTIVE = 12'h100;
    localparam logic [11:0] OFF_FAST = 12'h104;
    localparam logic [11:0] OFF_CUR = 12'h108;
    localparam logic [11:0] OFF_PEND = 12'h10c;
    localparam logic [11:0] OFF_ENAB = 12'h110;
    localparam logic [11:0] OFF_CORE = 12'h114;
    localparam logic [11:0] OFF_EN_CMD = 12'h120;
    localparam logic [11:0] OFF_DIS_CMD = 12'h124;
    localparam logic [11:0] OFF_CLR_CMD = 12'h128;
    localparam logic [11:0] OFF_SET_CMD = 12'h12c;
    localparam logic [11:0] OFF_EOS_CMD = 12'h130;
    localparam logic [11:0] OFF_SPUR = 12'h134;
    localparam logic [11:0] OFF_DBG = 12'h138;
    localparam logic [11:0] OFF_FF_EN = 12'h140;
    localparam logic [11:0] OFF_FF_DIS = 12'h144;
    localparam logic [11:0] OFF_FF_STATE = 12'h148;
    // mode and handler regions, selected by offset bits 11:7
    localparam logic [4:0] REGION_MODE = 5'h00;
    localparam logic [4:0] REGION_HANDLER = 5'h01;
    // field positions
    localparam int MODE_LVL_LSB = 0;
    localparam int MODE_KIND_LSB = 5;
    localparam int KIND_EDGE_BIT = 0;
    localparam int KIND_POL_BIT = 1;
    localparam int DBG_SAFE_BIT = 0;
    localparam int DBG_GMASK_BIT = 1;
    localparam int CORE_FAST_BIT = 0;
    localparam int CORE_NORMAL_BIT = 1;
    localparam int FAST_SRC = 0;
    typedef logic [2:0] viu_level_t;
    typedef logic [1:0] viu_kind_t;
endpackage

// >>> rtl/viu_regs.sv
`timescale 1ns/1ps
module viu_regs (
    // clock and reset
    input wire logic REF_CLK_I,
    input wire logic ARST_N_I,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [31:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // interrupt sources, asynchronous
    input wire logic [viu_pkg::NUM_SRC-1:0] IRQ_SRC_I,
    // core request lines, active low
    output logic NORMAL_REQ_N_O,
    output logic FAST_REQ_N_O
);
    import viu_pkg::*;

    // ==========================================
    // bus decode
    logic ack_reg;
    logic [31:0] dat_reg;
    wire acc = WB_CYC_I & WB_STB_I & ~ack_reg;
    wire in_win = WB_ADR_I[31:12] == VIU_BASE_PAGE;
    wire [11:0] off = WB_ADR_I[11:0];
    wire [SRC_ID_W-1:0] idx = off[6:2];
    wire wr = acc & WB_WE_I & in_win;
    wire rd = acc & ~WB_WE_I & in_win;

    function automatic logic [31:0] sel_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = WORD_ZERO;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{sel[b]}};
        end
        return m;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        return (old & ~sel_mask(sel)) | (nw & sel_mask(sel));
    endfunction

    wire [31:0] wd_m = WB_DAT_I & sel_mask(WB_SEL_I);
    wire wr_mode = wr & (off[11:7] == REGION_MODE);
    wire wr_handler = wr & (off[11:7] == REGION_HANDLER);
    // command bits written 0 or masked by sel leave sources alone
    wire [31:0] en_cmd = (wr && off == OFF_EN_CMD) ? wd_m : WORD_ZERO;
    wire [31:0] dis_cmd = (wr && off == OFF_DIS_CMD) ? wd_m : WORD_ZERO;
    wire [31:0] clr_cmd = (wr && off == OFF_CLR_CMD) ? wd_m : WORD_ZERO;
    wire [31:0] set_cmd = (wr && off == OFF_SET_CMD) ? wd_m : WORD_ZERO;
    wire [31:0] ffe_cmd = (wr && off == OFF_FF_EN) ? wd_m : WORD_ZERO;
    wire [31:0] ffd_cmd = (wr && off == OFF_FF_DIS) ? wd_m : WORD_ZERO;
    wire eos_wr = wr && off == OFF_EOS_CMD;
    wire act_rd = rd && off == OFF_ACTIVE;
    wire act_wr = wr && off == OFF_ACTIVE;
    wire fast_rd = rd && off == OFF_FAST;

    // ==========================================
    // source synchroniser: change taken when stages two and three agree
    logic [31:0] s1_reg, s2_reg, s3_reg, filt_reg, prev_reg;
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            s1_reg <= WORD_ZERO;
            s2_reg <= WORD_ZERO;
            s3_reg <= WORD_ZERO;
            filt_reg <= WORD_ZERO;
            prev_reg <= WORD_ZERO;
        end else begin
            s1_reg <= IRQ_SRC_I;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
            prev_reg <= filt_reg;
        end
    end

    // ==========================================
    // per-source mode, handler and pending state
    viu_level_t lvl_reg [NUM_SRC];
    viu_kind_t kind_reg [NUM_SRC];
    logic [31:0] handler_reg [NUM_SRC];
    logic [31:0] sticky_reg, enab_reg, ffs_reg;
    logic [31:0] act_lvl, act_prev, edge_mode, pending, ack_clr;
    logic [NUM_SRC*3-1:0] lvl_flat;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
            localparam logic [SRC_ID_W-1:0] SRC_IDX = SRC_ID_W'(gi);
            // only external sources may invert polarity
            wire inv = EXT_SRC_MASK[gi] & ~kind_reg[gi][KIND_POL_BIT];
            assign act_lvl[gi] = filt_reg[gi] ^ inv;
            assign act_prev[gi] = prev_reg[gi] ^ inv;
            assign edge_mode[gi] = kind_reg[gi][KIND_EDGE_BIT];
            assign lvl_flat[gi*3 +: 3] = lvl_reg[gi];
            always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
                if (!ARST_N_I) begin
                    lvl_reg[gi] <= 3'h0;
                    kind_reg[gi] <= 2'h0;
                    handler_reg[gi] <= WORD_ZERO;
                end else begin
                    if (wr_mode && idx == SRC_IDX && WB_SEL_I[0]) begin
                        lvl_reg[gi] <= WB_DAT_I[MODE_LVL_LSB +: 3];
                        kind_reg[gi] <= WB_DAT_I[MODE_KIND_LSB +: 2];
                    end
                    if (wr_handler && idx == SRC_IDX) begin
                        handler_reg[gi] <= merge(handler_reg[gi], WB_DAT_I, WB_SEL_I);
                    end
                end
            end
        end
    endgenerate

    // level sources follow the input, a set command latches
    assign pending = (edge_mode & sticky_reg) | (~edge_mode & (act_lvl | sticky_reg));
    wire [31:0] ready = pending & enab_reg;
    // edge capture wins over any clear in the same cycle
    wire [31:0] edge_hit = edge_mode & act_lvl & ~act_prev;

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sticky_reg <= WORD_ZERO;
            enab_reg <= WORD_ZERO;
            ffs_reg <= WORD_ZERO;
        end else begin
            sticky_reg <= (sticky_reg & ~clr_cmd & ~ack_clr) | edge_hit | set_cmd;
            enab_reg <= (enab_reg | en_cmd) & ~dis_cmd;
            ffs_reg <= (ffs_reg | ffe_cmd) & ~ffd_cmd;
        end
    end

    // ==========================================
    // priority selection
    // highest level wins, lowest number breaks a tie; source zero never ranked
    function automatic logic [SRC_ID_W:0] pick(input logic [31:0] m,
                                               input logic [NUM_SRC*3-1:0] lv);
        logic found;
        logic [SRC_ID_W-1:0] best;
        found = 1'b0;
        best = '0;
        for (int s = NUM_SRC - 1; s > FAST_SRC; s--) begin
            if (m[s] && (!found || lv[s*3 +: 3] >= lv[best*3 +: 3])) begin
                found = 1'b1;
                best = s[SRC_ID_W-1:0];
            end
        end
        return {found, best};
    endfunction

    logic cur_valid_reg, memo_valid_reg;
    logic [SRC_ID_W-1:0] cur_id_reg, memo_id_reg;
    viu_level_t cur_lvl_reg, memo_lvl_reg;
    logic [31:0] spur_reg;
    logic [1:0] dbg_reg;

    wire [31:0] norm_mask = ready & ~ffs_reg & ~(32'h1 << FAST_SRC);
    wire [SRC_ID_W:0] pick_res = pick(norm_mask, lvl_flat);
    wire [SRC_ID_W-1:0] cand_id = pick_res[SRC_ID_W-1:0];
    wire viu_level_t cand_lvl = lvl_reg[cand_id];
    wire cand_ok = pick_res[SRC_ID_W] & (~cur_valid_reg | (cand_lvl > cur_lvl_reg));
    wire fast_want = ready[FAST_SRC] | (|(ready & ffs_reg));
    wire safe_mode = dbg_reg[DBG_SAFE_BIT];
    wire gmask = dbg_reg[DBG_GMASK_BIT];

    // ==========================================
    // current interrupt context
    // single level held; a nested interrupt replaces the context until the
    // next end-of-service, no deeper stack is kept here
    wire commit_rd = act_rd & ~safe_mode & cand_ok;
    wire commit_wr = act_wr & safe_mode & memo_valid_reg;
    wire commit = commit_rd | commit_wr;
    wire [SRC_ID_W-1:0] commit_id = commit_rd ? cand_id : memo_id_reg;
    wire viu_level_t commit_lvl = commit_rd ? cand_lvl : memo_lvl_reg;
    // fast read leaves source zero alone while forcing is in use
    wire fast_clr = fast_rd & ~(|ffs_reg[31:1]);
    assign ack_clr = (commit ? (32'h1 << commit_id) : WORD_ZERO)
                   | (fast_clr ? (32'h1 << FAST_SRC) : WORD_ZERO);

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cur_valid_reg <= 1'b0;
            cur_id_reg <= '0;
            cur_lvl_reg <= 3'h0;
        end else if (commit) begin
            cur_valid_reg <= 1'b1;
            cur_id_reg <= commit_id;
            cur_lvl_reg <= commit_lvl;
        end else if (eos_wr) begin
            cur_valid_reg <= 1'b0;
        end
    end

    // safe mode: a read only remembers the choice
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            memo_valid_reg <= 1'b0;
            memo_id_reg <= '0;
            memo_lvl_reg <= 3'h0;
        end else if (act_rd && safe_mode) begin
            memo_valid_reg <= cand_ok;
            memo_id_reg <= cand_id;
            memo_lvl_reg <= cand_lvl;
        end else if (commit_wr) begin
            memo_valid_reg <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            spur_reg <= WORD_ZERO;
            dbg_reg <= 2'h0;
        end else begin
            if (wr && off == OFF_SPUR) begin
                spur_reg <= merge(spur_reg, WB_DAT_I, WB_SEL_I);
            end
            if (wr && off == OFF_DBG && WB_SEL_I[0]) begin
                dbg_reg <= WB_DAT_I[1:0];
            end
        end
    end

    // ==========================================
    // read data selection
    wire [31:0] active_addr = cand_ok ? handler_reg[cand_id] : spur_reg;
    wire [31:0] fast_addr = fast_want ? handler_reg[FAST_SRC] : spur_reg;
    wire [31:0] mode_word = {24'h0, 1'b0, kind_reg[idx], 2'h0, lvl_reg[idx]};
    wire [31:0] core_word = {30'h0, ~NORMAL_REQ_N_O, ~FAST_REQ_N_O};
    wire [31:0] cur_word = {27'h0, cur_id_reg};
    // write-only and reserved offsets fall through to zero
    wire [31:0] rdata =
        (off[11:7] == REGION_MODE) ? mode_word :
        (off[11:7] == REGION_HANDLER) ? handler_reg[idx] :
        (off == OFF_ACTIVE) ? active_addr :
        (off == OFF_FAST) ? fast_addr :
        (off == OFF_CUR) ? cur_word :
        (off == OFF_PEND) ? pending :
        (off == OFF_ENAB) ? enab_reg :
        (off == OFF_CORE) ? core_word :
        (off == OFF_SPUR) ? spur_reg :
        (off == OFF_DBG) ? {30'h0, dbg_reg} :
        (off == OFF_FF_STATE) ? ffs_reg : WORD_ZERO;

    // every cycle request is answered, outside the window with zero
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ack_reg <= 1'b0;
            dat_reg <= WORD_ZERO;
        end else begin
            ack_reg <= acc;
            dat_reg <= rd ? rdata : WORD_ZERO;
        end
    end

    // ==========================================
    // request lines, registered so the core sees no decode glitches
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            NORMAL_REQ_N_O <= 1'b1;
            FAST_REQ_N_O <= 1'b1;
        end else begin
            NORMAL_REQ_N_O <= ~(cand_ok & ~gmask);
            FAST_REQ_N_O <= ~(fast_want & ~gmask);
        end
    end

    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = dat_reg;

    // ==========================================
    // checks
    sequence safe_read_s;
        act_rd && safe_mode;
    endsequence

    sequence eos_s;
        eos_wr && !commit;
    endsequence

    ack_single_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");

    gmask_lines_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        gmask |=> NORMAL_REQ_N_O && FAST_REQ_N_O)
        else $error("request line active under global mask");

    eos_ends_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        eos_s |=> !cur_valid_reg)
        else $error("end-of-service left interrupt current");

    spur_read_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        act_rd && !cand_ok |=> WB_ACK_O && WB_DAT_O == $past(spur_reg))
        else $error("spurious handler not returned");

    fast_vec_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        fast_rd && fast_want |=> WB_DAT_O == $past(handler_reg[0]))
        else $error("fast handler read wrong");

    enable_cmd_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (wr && off == OFF_EN_CMD) |=> enab_reg == ($past(enab_reg) | $past(wd_m)))
        else $error("enable command disturbed other sources");

    safe_read_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        safe_read_s |=> $stable(cur_valid_reg) && $stable(cur_id_reg))
        else $error("safe read changed current context");

    reserved_read_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        rd && (off == OFF_EN_CMD || off == OFF_EOS_CMD || off == 12'h118)
        |=> WB_DAT_O == WORD_ZERO)
        else $error("write-only or reserved read not zero");

    active_vec_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        act_rd && cand_ok && !safe_mode |=> WB_DAT_O == handler_reg[cur_id_reg])
        else $error("active handler not that of the current source");

    core_status_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        rd && off == OFF_CORE
        |=> WB_DAT_O[CORE_NORMAL_BIT] == !$past(NORMAL_REQ_N_O))
        else $error("core status does not follow normal line");

    sequence safe_commit_s;
        act_wr && safe_mode && memo_valid_reg;
    endsequence

    bus_answer_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        acc |=> WB_ACK_O)
        else $error("bus request not answered in one cycle");

    disable_cmd_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (wr && off == OFF_DIS_CMD) |=> enab_reg == ($past(enab_reg) & ~$past(wd_m)))
        else $error("disable command disturbed other sources");

    set_cmd_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (wr && off == OFF_SET_CMD) |=> (sticky_reg & $past(wd_m)) == $past(wd_m))
        else $error("set command did not latch its sources");

    ff_state_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (wr && off == OFF_FF_EN) |=> ffs_reg == ($past(ffs_reg) | $past(wd_m)))
        else $error("fast force enable did not update state");

    safe_commit_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        safe_commit_s |=> cur_valid_reg && cur_id_reg == $past(memo_id_reg))
        else $error("safe mode write did not commit remembered source");
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
    import viu_pkg::*;
    logic clk;
    logic rst_n;
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [31:0] adr;
    logic [31:0] wdat;
    logic [31:0] dat_o;
    logic [31:0] rdat;
    logic [31:0] src;
    logic ack;
    logic req_n;
    logic fiq_n;
    logic irq_on;
    logic fiq_on;
    int num_errors = 0;
    int checks_done = 0;
    // ==========================================
    // clock, design and core model
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    viu_regs dut (.REF_CLK_I(clk), .ARST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .IRQ_SRC_I(src), .NORMAL_REQ_N_O(req_n), .FAST_REQ_N_O(fiq_n));
    viu_core_model core (.clk_i(clk), .rst_n_i(rst_n), .normal_req_n_i(req_n),
        .fast_req_n_i(fiq_n), .irq_on_o(irq_on), .fiq_on_o(fiq_on));
    // ==========================================
    // bus and line helpers
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) num_errors++;
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] off, input logic [31:0] d);
        wb(1'b1, {VIU_BASE_PAGE, off}, d);
    endtask
    task automatic rc(input logic [11:0] off, input logic [31:0] e);
        wb(1'b0, {VIU_BASE_PAGE, off}, WORD_ZERO);
        `CHK(rdat, e)
    endtask
    // bounded wait for the core to see the expected line state
    task automatic wl(input logic i, input logic f);
        int n;
        n = 0;
        while ({irq_on, fiq_on} !== {i, f} && n < 40) begin
            @(posedge clk);
            n++;
        end
        `CHK({irq_on, fiq_on}, {i, f})
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset();
        repeat (8) @(posedge clk);
        rc(12'h000, 32'h0);
        rc(12'h0fc, 32'h0);
        rc(OFF_SPUR, 32'h0);
        rc(OFF_FF_STATE, 32'h0);
        rc(OFF_CORE, 32'h0);
        rc(OFF_PEND, 32'h0);
        rc(OFF_ENAB, 32'h0);
    endtask
    task automatic t_regs();
        wr(12'h014, 32'hffff_ffff);
        rc(12'h014, 32'h0000_0067);
        wr(12'h0fc, 32'h1234_5678);
        rc(12'h0fc, 32'h1234_5678);
        wr(12'h118, 32'hffff_ffff);
        rc(12'h118, 32'h0);
        rc(OFF_EN_CMD, 32'h0);
        rc(OFF_EOS_CMD, 32'h0);
        wb(1'b1, 32'hfffe_f134, 32'hdead_beef);
        rc(OFF_SPUR, 32'h0);
        wr(OFF_FF_EN, 32'h0000_0041);
        rc(OFF_FF_STATE, 32'h0000_0041);
        wr(OFF_FF_DIS, 32'h0000_0041);
        rc(OFF_FF_STATE, 32'h0);
    endtask
    task automatic t_vector();
        wr(OFF_SPUR, 32'h0000_0bad);
        wr(12'h014, 32'h0000_0023);
        wr(12'h094, 32'h1000_0500);
        wr(12'h018, 32'h0000_0002);
        wr(12'h098, 32'h1000_0600);
        wr(OFF_EN_CMD, 32'h0000_0060);
        src[5] <= 1'b1;
        wl(1'b1, 1'b0);
        rc(OFF_CORE, 32'h2);
        rc(OFF_ACTIVE, 32'h1000_0500);
        rc(OFF_CUR, 32'h5);
        // level 2 may not preempt level 3 while that one is in service
        wr(OFF_SET_CMD, 32'h0000_0040);
        repeat (6) @(posedge clk);
        wl(1'b0, 1'b0);
        wr(OFF_EOS_CMD, 32'h0000_1234);
        wl(1'b1, 1'b0);
        rc(OFF_ACTIVE, 32'h1000_0600);
        wr(OFF_EOS_CMD, 32'h0);
        rc(OFF_ACTIVE, 32'h0000_0bad);
        src[5] <= 1'b0;
    endtask
    task automatic t_fast();
        wr(12'h080, 32'h2000_0000);
        rc(OFF_FAST, 32'h0000_0bad);
        wr(12'h000, 32'h0000_0047);
        wr(OFF_EN_CMD, 32'h0000_0001);
        wl(1'b0, 1'b1);
        rc(OFF_FAST, 32'h2000_0000);
        rc(OFF_ACTIVE, 32'h0000_0bad);
        wr(OFF_DBG, 32'h0000_0002);
        wl(1'b0, 1'b0);
        wr(OFF_SET_CMD, 32'h0000_0020);
        repeat (6) @(posedge clk);
        wl(1'b0, 1'b0);
        wr(OFF_DBG, 32'h0);
        wl(1'b1, 1'b1);
        rc(OFF_CORE, 32'h3);
        wr(OFF_DIS_CMD, 32'h0000_0021);
        wl(1'b0, 1'b0);
        rc(OFF_ENAB, 32'h0000_0040);
        wr(OFF_CLR_CMD, 32'h0000_0020);
        rc(OFF_PEND, 32'h0000_0001);
        wr(12'h000, 32'h0);
    endtask
    task automatic t_kinds();
        wr(12'h01c, 32'h0000_0040);
        wr(12'h07c, 32'h0000_0020);
        src[7] <= 1'b1;
        src[30] <= 1'b0;
        src[31] <= 1'b0;
        // fixed settle time covers the input synchroniser
        repeat (8) @(posedge clk);
        rc(OFF_PEND, 32'hc000_0080);
        src[7] <= 1'b0;
        src[30] <= 1'b1;
        src[31] <= 1'b1;
        repeat (8) @(posedge clk);
        rc(OFF_PEND, 32'h8000_0000);
        wr(OFF_CLR_CMD, 32'h8000_0000);
        rc(OFF_PEND, 32'h0);
    endtask
    task automatic t_safe();
        wr(OFF_DBG, 32'h0000_0001);
        wr(OFF_EN_CMD, 32'h0000_0020);
        wr(OFF_SET_CMD, 32'h0000_0020);
        wl(1'b1, 1'b0);
        rc(OFF_ACTIVE, 32'h1000_0500);
        rc(OFF_CUR, 32'h6);
        repeat (6) @(posedge clk);
        wl(1'b1, 1'b0);
        wr(OFF_ACTIVE, 32'h0);
        rc(OFF_CUR, 32'h5);
        wl(1'b0, 1'b0);
        wr(OFF_EOS_CMD, 32'h0);
        wr(OFF_DBG, 32'h0);
    endtask
    // ==========================================
    // verdict and run control
    task automatic test_done();
        if (num_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        test_done();
    end
    initial begin
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        sel = 4'hf;
        adr = 32'h0;
        wdat = 32'h0;
        // external sources idle high so low-level modes stay quiet
        src = EXT_SRC_MASK;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_vector();
        t_fast();
        t_kinds();
        t_safe();
        test_done();
    end
endmodule

// >>> sim/viu_core_model.sv
`timescale 1ns/1ps
// ==========================================
// processor side of the two request lines
module viu_core_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // request lines from the controller, active low
    input wire logic normal_req_n_i,
    input wire logic fast_req_n_i,
    // what the core has registered
    output logic irq_on_o,
    output logic fiq_on_o
);
    // the core registers the lines, so it reacts one clock late
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_on_o <= 1'b0;
            fiq_on_o <= 1'b0;
        end else begin
            irq_on_o <= !normal_req_n_i;
            fiq_on_o <= !fast_req_n_i;
        end
    end
endmodule
